// ===== include/ddsp_pkg.sv
// Shared constants, types and helper functions of the door driver serial control block.
`default_nettype none

package ddsp_pkg;

  // Frame geometry: 16 bits, two address bits and a clear request at the bottom.
  localparam int FRAME_BITS = 16;
  localparam int DATA_BITS = 13;
  localparam int DIAG_BITS = 10;
  localparam int CNT_BITS = 5;

  // Power stage population: six half-bridges plus five lone high-side switches.
  localparam int SWITCHES = 17;
  localparam int BRIDGES = 6;
  localparam int PWM_STAGES = 13;
  localparam int UPPER_FIRST = 7;

  // Register addresses carried in a frame.
  localparam logic [1:0] ADDR_AFTER_RESET = 2'h0;
  localparam logic [1:0] ADDR_OVL_LOWER = 2'h0;
  localparam logic [1:0] ADDR_OPEN_LOWER = 2'h1;
  localparam logic [1:0] ADDR_OVL_UPPER = 2'h2;
  localparam logic [1:0] ADDR_OPEN_UPPER = 2'h3;
  localparam logic [1:0] ADDR_SELECT_A = 2'h1;
  localparam logic [1:0] ADDR_SELECT_B = 2'h3;

  // Positions of the address independent status bits.
  localparam int STAT_SUPPLY_BIT = 5;
  localparam int STAT_TSD_BIT = 4;
  localparam int STAT_WARN_BIT = 3;

  // Values after reset.
  localparam logic [DATA_BITS-1:0] CTRL_RESET = 13'h0000;
  localparam logic [SWITCHES-1:0] FLAGS_RESET = 17'h00000;
  localparam logic [FRAME_BITS-1:0] WORD_RESET = 16'h0000;
  localparam logic [CNT_BITS-1:0] CNT_RESET = 5'h00;

  // Switches that own an open load bit; the others read as fixed low.
  localparam logic [SWITCHES-1:0] OPEN_LOAD_MASK = 17'h1ead5;

  // Timing: core clock period, shutdown delay and least dead time.
  localparam int CLK_PERIOD_NS = 5;
  localparam int SHUTDOWN_DELAY_NS = 25000;
  localparam int SHUTDOWN_CYCLES = SHUTDOWN_DELAY_NS / CLK_PERIOD_NS;
  localparam int DEAD_TIME_NS = 3000;
  localparam int DEAD_CYCLES = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_BITS = 10;
  localparam int NODATA_TIME_US = 5;

  // One received frame.
  typedef struct packed {
    logic [DATA_BITS-1:0] data;
    logic clear_req;
    logic [1:0] addr;
  } ddsp_frame_t;

  // Address independent status inputs after synchronisation.
  typedef struct packed {
    logic supply_fail;
    logic over_temp;
    logic temp_warning;
  } ddsp_common_t;

  // Serial output sequencer states.
  typedef enum logic [0:0] {
    LINK_IDLE = 1'b0,
    LINK_ACTIVE = 1'b1
  } ddsp_link_state_t;

  // Half-bridge that a switch belongs to, or -1 for a lone high-side switch.
  function automatic int bridge_of(input int sw);
    if (sw < 6) begin
      return sw / 2;
    end else if (sw >= UPPER_FIRST && sw < UPPER_FIRST + 6) begin
      return 3 + (sw - UPPER_FIRST) / 2;
    end
    return -1;
  endfunction : bridge_of

  // Low-side switch index of a half-bridge; the high side is the next index.
  function automatic int low_of(input int br);
    return (br < 3) ? 2 * br : UPPER_FIRST + 2 * (br - 3);
  endfunction : low_of

endpackage : ddsp_pkg

`default_nettype wire

// ===== rtl/ddsp_sync.sv
// Two flip-flop synchroniser with a selectable reset value per bit.
`default_nettype none

module ddsp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset of the receiving domain.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Asynchronous input and its synchronised copy.
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  // The first stage is read only by the second stage.
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // Next values: both stages simply advance.
  always_comb begin
    next_meta = d_i;
    next_q = meta;
  end

  // Registers with a constant reset value.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end

endmodule : ddsp_sync

`default_nettype wire

// ===== rtl/ddsp_top.sv
// Serial control, diagnosis and protection logic of the door driver power stages.
`default_nettype none

module ddsp_top #(
  parameter int SHUTDOWN_CYCLES = ddsp_pkg::SHUTDOWN_CYCLES,
  parameter int DEAD_CYCLES = ddsp_pkg::DEAD_CYCLES
) (
  // Core clock and asynchronous active low reset.
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Serial link; the serial clock clocks the receive shift register.
  input wire logic link_sclk_i,
  input wire logic select_low_i,
  input wire logic serial_in_pin_i,
  output logic serial_out_o,
  output logic serial_out_oe_n_o,
  // External modulation inputs.
  input wire logic modulation_input_a_i,
  input wire logic modulation_input_b_i,
  // Analog monitor results, one bit per switch where applicable.
  input wire logic [ddsp_pkg::SWITCHES-1:0] over_current_i,
  input wire logic [ddsp_pkg::SWITCHES-1:0] open_load_i,
  input wire logic over_temp_i,
  input wire logic temp_warning_i,
  input wire logic supply_fail_i,
  // Switch gate commands and summary flags.
  output logic [ddsp_pkg::SWITCHES-1:0] stage_drive_o,
  output logic summary_error_flag_o,
  output logic thermal_shutdown_flag_o
);

  localparam int NSW = ddsp_pkg::SWITCHES;
  localparam int OC_BITS = $clog2(SHUTDOWN_CYCLES + 1);

  //////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers.

  logic rst_n; // Released copy of the reset used everywhere else.
  logic sel_s; // Synchronised select, low during a frame.
  logic sclk_s; // Synchronised serial clock, only used for edge detection.
  logic sclk_d; // Previous synchronised serial clock.
  logic pwm_a_s; // Synchronised modulation input a.
  logic pwm_b_s; // Synchronised modulation input b.
  logic [NSW-1:0] oc_s; // Synchronised overcurrent comparators.
  logic [NSW-1:0] ol_s; // Synchronised open load detectors.
  ddsp_pkg::ddsp_common_t com_s; // Synchronised address independent inputs.

  // Reset is asserted at once and released two edges later.
  ddsp_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_rst_sync (
    .clk_i(core_clk_i),
    .rst_n_i(arst_n_i),
    .d_i(1'b1),
    .q_o(rst_n)
  );

  // Select resets to idle so that reset never fakes a frame start.
  ddsp_sync #(.WIDTH(2), .RESET_VAL(2'b10)) u_link_sync (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .d_i({select_low_i, link_sclk_i}),
    .q_o({sel_s, sclk_s})
  );

  // Every pin level that the protection logic reads.
  ddsp_sync #(.WIDTH(2 * NSW + 5), .RESET_VAL('0)) u_pin_sync (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .d_i({modulation_input_a_i, modulation_input_b_i, over_current_i, open_load_i,
          supply_fail_i, over_temp_i, temp_warning_i}),
    .q_o({pwm_a_s, pwm_b_s, oc_s, ol_s, com_s})
  );

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: the receive shift register on the serial clock.

  logic [ddsp_pkg::FRAME_BITS-1:0] rx_shift;
  logic [ddsp_pkg::FRAME_BITS-1:0] next_rx_shift;

  // Input data are sampled on rising serial clock edges, first bit at the top.
  always_comb begin
    next_rx_shift = {rx_shift[ddsp_pkg::FRAME_BITS-2:0], serial_in_pin_i};
  end

  // The core only reads this word once select has been high for two core
  // edges, while the serial clock stands still, so the word is stable.
  always_ff @(posedge link_sclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift <= ddsp_pkg::WORD_RESET;
    end else begin
      rx_shift <= next_rx_shift;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status assembly.

  logic [NSW-1:0] ovl; // Latched overload flags.
  logic [NSW-1:0] opl; // Latched open load flags.
  logic thermal_shutdown_flag; // Latched thermal shutdown flag.
  logic [1:0] read_addr; // Register returned in the next frame.
  logic [3:0] reg_err; // Per register error flags.
  logic [ddsp_pkg::FRAME_BITS-1:0] status_word; // Word for the coming frame.

  // Diagnostic bits 15 down to 6 of one status register.
  function automatic logic [ddsp_pkg::DIAG_BITS-1:0] diag_of(
      input logic [1:0] a,
      input logic [NSW-1:0] ov,
      input logic [NSW-1:0] op);
    logic [NSW-1:0] src;
    logic [ddsp_pkg::DIAG_BITS-1:0] d;
    src = a[0] ? (op & ddsp_pkg::OPEN_LOAD_MASK) : ov;
    d = '0;
    for (int k = 0; k < ddsp_pkg::DIAG_BITS; k++) begin
      if (!a[1] && k < ddsp_pkg::UPPER_FIRST) begin
        d[ddsp_pkg::DIAG_BITS-1-k] = src[k];
      end else if (a[1]) begin
        d[ddsp_pkg::DIAG_BITS-1-k] = src[ddsp_pkg::UPPER_FIRST+k];
      end
    end
    return d;
  endfunction : diag_of

  // Build the word: addressed bits, common bits, then the other three flags.
  always_comb begin
    int slot;
    slot = 2;
    for (int r = 0; r < 4; r++) begin
      reg_err[r] = |diag_of(2'(r), ovl, opl);
    end
    status_word = {diag_of(read_addr, ovl, opl), 6'h00};
    status_word[ddsp_pkg::STAT_SUPPLY_BIT] = com_s.supply_fail;
    status_word[ddsp_pkg::STAT_TSD_BIT] = thermal_shutdown_flag;
    status_word[ddsp_pkg::STAT_WARN_BIT] = com_s.temp_warning;
    for (int r = 3; r >= 0; r--) begin
      if (2'(r) != read_addr) begin
        status_word[slot] = reg_err[r];
        slot = slot - 1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial sequencer, frame decode and control words.

  ddsp_pkg::ddsp_link_state_t state;
  ddsp_pkg::ddsp_link_state_t next_state;
  logic [ddsp_pkg::FRAME_BITS-1:0] tx_shift;
  logic [ddsp_pkg::FRAME_BITS-1:0] next_tx_shift;
  logic [ddsp_pkg::CNT_BITS-1:0] bit_cnt;
  logic [ddsp_pkg::CNT_BITS-1:0] next_bit_cnt;
  logic next_do;
  logic next_oe_n;
  logic next_sclk_d;
  logic [1:0] next_read_addr;
  logic clear_pend; // Clear requested by the previous frame.
  logic next_clear_pend;
  logic do_clear; // Pulse: clear the register that was just read.
  logic [1:0] clear_addr; // Register that the pulse clears.
  logic [ddsp_pkg::DATA_BITS-1:0] ctrl [4]; // Control words by address.
  logic [ddsp_pkg::DATA_BITS-1:0] next_ctrl [4];
  ddsp_pkg::ddsp_frame_t frame;

  assign frame = ddsp_pkg::ddsp_frame_t'(rx_shift);

  // Next values of the link sequencer and of everything a frame updates.
  always_comb begin
    next_state = state;
    next_tx_shift = tx_shift;
    next_bit_cnt = bit_cnt;
    next_do = serial_out_o;
    next_oe_n = serial_out_oe_n_o;
    next_sclk_d = sclk_s;
    next_read_addr = read_addr;
    next_clear_pend = clear_pend;
    next_ctrl = ctrl;
    do_clear = 1'b0;
    clear_addr = read_addr;
    case (state)
      ddsp_pkg::LINK_IDLE: begin
        if (!sel_s) begin
          // Freeze the status so changes during the frame cannot tear it.
          next_tx_shift = status_word;
          next_do = |reg_err;
          next_oe_n = 1'b0;
          next_bit_cnt = ddsp_pkg::CNT_RESET;
          next_state = ddsp_pkg::LINK_ACTIVE;
        end
      end
      ddsp_pkg::LINK_ACTIVE: begin
        if (sel_s) begin
          next_oe_n = 1'b1;
          next_do = 1'b0;
          next_state = ddsp_pkg::LINK_IDLE;
          // Short frames are dropped whole; long ones keep the last 16 bits.
          if (bit_cnt >= ddsp_pkg::CNT_BITS'(ddsp_pkg::FRAME_BITS)) begin
            do_clear = clear_pend;
            next_clear_pend = frame.clear_req;
            next_read_addr = frame.addr;
            next_ctrl[frame.addr] = frame.data;
          end
        end else if (sclk_s && !sclk_d) begin
          // Each rising serial edge brings the next bit, top first.
          next_do = tx_shift[ddsp_pkg::FRAME_BITS-1];
          next_tx_shift = {tx_shift[ddsp_pkg::FRAME_BITS-2:0], 1'b0};
          if (bit_cnt != '1) begin
            next_bit_cnt = bit_cnt + 1'b1;
          end
        end
      end
      default: begin
        next_state = ddsp_pkg::LINK_IDLE;
      end
    endcase
  end

  // Sequencer and control registers.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ddsp_pkg::LINK_IDLE;
      tx_shift <= ddsp_pkg::WORD_RESET;
      bit_cnt <= ddsp_pkg::CNT_RESET;
      serial_out_o <= 1'b0;
      serial_out_oe_n_o <= 1'b1;
      sclk_d <= 1'b0;
      read_addr <= ddsp_pkg::ADDR_AFTER_RESET;
      clear_pend <= 1'b0;
      for (int r = 0; r < 4; r++) begin
        ctrl[r] <= ddsp_pkg::CTRL_RESET;
      end
    end else begin
      state <= next_state;
      tx_shift <= next_tx_shift;
      bit_cnt <= next_bit_cnt;
      serial_out_o <= next_do;
      serial_out_oe_n_o <= next_oe_n;
      sclk_d <= next_sclk_d;
      read_addr <= next_read_addr;
      clear_pend <= next_clear_pend;
      ctrl <= next_ctrl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per bridge interlock and dead time.

  logic [ddsp_pkg::BRIDGES-1:0] conflict; // Both switches of a bridge requested.
  logic [ddsp_pkg::BRIDGES-1:0] dead_busy; // Dead time still running.
  logic [NSW-1:0] on_bit; // Serial on-bits, one per switch.
  logic [NSW-1:0] next_drive;

  for (genvar b = 0; b < ddsp_pkg::BRIDGES; b++) begin : g_bridge
    localparam int LS = ddsp_pkg::low_of(b);
    logic [ddsp_pkg::DEAD_BITS-1:0] dead_cnt;
    logic [ddsp_pkg::DEAD_BITS-1:0] next_dead_cnt;

    // Low side and high side requested together is refused as a whole.
    assign conflict[b] = on_bit[LS] & on_bit[LS+1];
    assign dead_busy[b] = (dead_cnt != '0);

    // Any switch of the bridge turning off starts the dead time, which
    // keeps the opposite slope from starting until the first has ended.
    always_comb begin
      next_dead_cnt = dead_cnt;
      if ((stage_drive_o[LS] && !next_drive[LS]) ||
          (stage_drive_o[LS+1] && !next_drive[LS+1])) begin
        next_dead_cnt = ddsp_pkg::DEAD_BITS'(DEAD_CYCLES);
      end else if (dead_busy[b]) begin
        next_dead_cnt = dead_cnt - 1'b1;
      end
    end

    // Dead time counter.
    always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        dead_cnt <= '0;
      end else begin
        dead_cnt <= next_dead_cnt;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per switch command, overcurrent shutdown and diagnosis latches.

  for (genvar i = 0; i < NSW; i++) begin : g_switch
    localparam int BR = ddsp_pkg::bridge_of(i);
    localparam logic [1:0] OVL_ADDR =
        (i < ddsp_pkg::UPPER_FIRST) ? ddsp_pkg::ADDR_OVL_LOWER : ddsp_pkg::ADDR_OVL_UPPER;
    // The same word holds the on-bit; the first switch of a group sits at the top.
    localparam int ON_POS = (i < ddsp_pkg::UPPER_FIRST) ? ddsp_pkg::DATA_BITS - 1 - i :
        ddsp_pkg::DATA_BITS - 1 + ddsp_pkg::UPPER_FIRST - i;
    logic [OC_BITS-1:0] oc_cnt;
    logic [OC_BITS-1:0] next_oc_cnt;
    logic next_ovl;
    logic next_opl;
    logic cmd; // On-bit combined with the modulation inputs.
    logic sel_a;
    logic sel_b;
    logic blocked; // Interlock or dead time holds the switch off.
    logic clr_ovl;
    logic clr_opl;

    assign on_bit[i] = ctrl[OVL_ADDR][ON_POS];

    // Only the first stages carry selection bits in words one and three.
    if (i < ddsp_pkg::PWM_STAGES) begin : g_sel
      assign sel_a = ctrl[ddsp_pkg::ADDR_SELECT_A][ddsp_pkg::DATA_BITS-1-i];
      assign sel_b = ctrl[ddsp_pkg::ADDR_SELECT_B][ddsp_pkg::DATA_BITS-1-i];
    end else begin : g_nosel
      assign sel_a = 1'b0;
      assign sel_b = 1'b0;
    end

    if (BR >= 0) begin : g_br
      // An off switch waits until its partner is off and the dead time is over,
      // so one frame that swaps the two sides never overlaps their slopes.
      localparam int MATE = (i == ddsp_pkg::low_of(BR)) ? i + 1 : i - 1;
      assign blocked = conflict[BR] |
                       (~stage_drive_o[i] & (dead_busy[BR] | stage_drive_o[MATE]));
    end else begin : g_lone
      assign blocked = 1'b0;
    end

    // A clear resets the latches of the register that was just read.
    assign clr_ovl = do_clear & (clear_addr == OVL_ADDR);
    assign clr_opl = do_clear & (clear_addr == (OVL_ADDR | 2'h1));

    // Stage command: off without the on-bit, else per the selection bits.
    always_comb begin
      if (!on_bit[i]) begin
        cmd = 1'b0;
      end else if (!sel_a && !sel_b) begin
        cmd = 1'b1;
      end else begin
        cmd = (sel_a & pwm_a_s) | (sel_b & pwm_b_s);
      end
      next_drive[i] = cmd & ~ovl[i] & ~thermal_shutdown_flag & ~blocked;
    end

    // Overcurrent timing and the sticky flags; a new event beats a clear.
    always_comb begin
      next_oc_cnt = '0;
      if (stage_drive_o[i] && oc_s[i] && oc_cnt != OC_BITS'(SHUTDOWN_CYCLES)) begin
        next_oc_cnt = oc_cnt + 1'b1;
      end
      next_ovl = ovl[i] & ~clr_ovl;
      if ((stage_drive_o[i] && oc_s[i] && oc_cnt == OC_BITS'(SHUTDOWN_CYCLES)) ||
          (BR >= 0 && conflict[(BR >= 0) ? BR : 0]) ||
          (stage_drive_o[i] && com_s.over_temp)) begin
        next_ovl = 1'b1;
      end
      next_opl = (opl[i] & ~clr_opl) |
                 (stage_drive_o[i] & ol_s[i] & ddsp_pkg::OPEN_LOAD_MASK[i]);
    end

    // Switch registers.
    always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        oc_cnt <= '0;
        ovl[i] <= 1'b0;
        opl[i] <= 1'b0;
        stage_drive_o[i] <= 1'b0;
      end else begin
        oc_cnt <= next_oc_cnt;
        ovl[i] <= next_ovl;
        opl[i] <= next_opl;
        stage_drive_o[i] <= next_drive[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Thermal flag and summary outputs.

  logic next_tsd;
  logic next_summary;

  // Over-temperature sets the thermal flag; any register clear resets it,
  // but a persisting over-temperature wins over the clear.
  always_comb begin
    next_tsd = (thermal_shutdown_flag & ~do_clear) | com_s.over_temp;
    next_summary = |reg_err;
  end

  // Thermal and summary registers.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      thermal_shutdown_flag <= 1'b0;
      summary_error_flag_o <= 1'b0;
      thermal_shutdown_flag_o <= 1'b0;
    end else begin
      thermal_shutdown_flag <= next_tsd;
      summary_error_flag_o <= next_summary;
      thermal_shutdown_flag_o <= next_tsd;
    end
  end

endmodule : ddsp_top

`default_nettype wire

// ===== verification/ddsp_monitor.sv
// Concurrent checks on the serial output and stage drive of the top module.
`default_nettype none
module ddsp_monitor #(
  parameter int SHUTDOWN_CYCLES = 20
) (
  // Core clock and reset.
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Watched link, stage and flag signals.
  input wire logic select_low_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_n_o,
  input wire logic [ddsp_pkg::SWITCHES-1:0] over_current_i,
  input wire logic [ddsp_pkg::SWITCHES-1:0] stage_drive_o,
  input wire logic summary_error_flag_o,
  input wire logic thermal_shutdown_flag_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] ovc_cnt; // Cycles switch 0 has been driven into an overcurrent.
  logic [15:0] next_ovc_cnt;
  // Counting beats a long repetition, which the tools would have to unroll.
  always_comb begin
    next_ovc_cnt = (over_current_i[0] && stage_drive_o[0]) ? ovc_cnt + 16'h0001 : 16'h0000;
  end
  // Register the count.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovc_cnt <= 16'h0000;
    end else begin
      ovc_cnt <= next_ovc_cnt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_start; $fell(select_low_i); endsequence
  sequence s_end; $rose(select_low_i); endsequence
  a_flag_before_clk: assert property (s_start |-> ##[1:6] !serial_out_oe_n_o)
    else $error("output not enabled after select fell");
  a_release_bound: assert property (s_end |-> ##[1:6] serial_out_oe_n_o)
    else $error("output not released after select rose");
  a_idle_low: assert property (serial_out_oe_n_o |-> !serial_out_o)
    else $error("data output high while disabled");
  a_out_framed: assert property ($changed(serial_out_o) |->
      !serial_out_oe_n_o || $rose(serial_out_oe_n_o))
    else $error("data output moved outside a frame");
  a_flag_value: assert property ($fell(serial_out_oe_n_o) |->
      serial_out_o == summary_error_flag_o || serial_out_o == $past(summary_error_flag_o))
    else $error("leading bit differs from the error flag");
  a_no_cross: assert property (
      (stage_drive_o & (stage_drive_o >> 1) & 17'h00a95) == 17'h00000)
    else $error("both switches of a bridge driven");
  a_dead_to_high: assert property ($fell(stage_drive_o[0]) |-> (!stage_drive_o[1]) [*8])
    else $error("high switch turned on inside the dead time");
  a_dead_to_low: assert property ($fell(stage_drive_o[1]) |-> (!stage_drive_o[0]) [*8])
    else $error("low switch turned on inside the dead time");
  a_tsd_off: assert property (thermal_shutdown_flag_o && $past(thermal_shutdown_flag_o, 2) |->
      stage_drive_o == 17'h00000)
    else $error("stage driven during thermal shutdown");
  a_ovc_bound: assert property (ovc_cnt <= 16'(SHUTDOWN_CYCLES + 6))
    else $error("overcurrent switch not shut down in time");
endmodule : ddsp_monitor
bind ddsp_top ddsp_monitor #(.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES)) ddsp_monitor_i (.core_clk_i,
  .arst_n_i, .select_low_i, .serial_out_o, .serial_out_oe_n_o, .over_current_i, .stage_drive_o,
  .summary_error_flag_o, .thermal_shutdown_flag_o);
`default_nettype wire

// ===== verification/ddsp_host_model.sv
// Behavioural host master of the serial link with an 80 ns serial clock.
`default_nettype none
module ddsp_host_model (
  // Link pins seen from the master.
  output logic sclk_o,
  output logic select_low_o,
  output logic mosi_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [16:0] last_rx; // Leading flag in bit 16, then the frame.
  event done; // Fires once a frame has been read back.
  // The serial clock stands low outside frames.
  initial begin
    sclk_o = 1'b0;
    select_low_o = 1'b1;
    mosi_o = 1'b0;
  end
  // One whole frame, most significant bit first; status comes back a frame later.
  task automatic xfer(input logic [15:0] tx);
    #13 select_low_o = 1'b0;
    #150 last_rx[16] = miso_i; // Flag is sampled before any clock edge.
    for (int i = 15; i >= 0; i--) begin
      mosi_o = tx[i];
      #40 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
      last_rx[i] = miso_i;
    end
    #100 select_low_o = 1'b1;
    mosi_o = ~mosi_o; // A released line must not keep its last value.
    -> done;
    #5000; // Idle gap between commands.
  endtask : xfer
endmodule : ddsp_host_model
`default_nettype wire

// ===== verification/ddsp_tb_top.sv
// Self-checking bench of the serial control and stage drive block.
`default_nettype none
`define DDSP_CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module ddsp_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SD = 20; // Shortened shutdown delay keeps the run brief.
  logic core_clk = 1'b0;
  logic arst_n, sclk, sel_low, mosi, dout, oe_n, mod_a, mod_b, otemp, ef, thermal_shutdown_flag;
  logic [16:0] ovc, drive;
  logic [16:0] exp_q[$]; // Expected frames, oldest first.
  logic [16:0] exp_frame; // Oldest note, taken off once per frame.
  int n_fail = 0;
  int compares = 0;
  always #2.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  ddsp_host_model ddsp_host_model_i (.sclk_o(sclk), .select_low_o(sel_low), .mosi_o(mosi),
    .miso_i(dout));
  ddsp_top #(.SHUTDOWN_CYCLES(SD), .DEAD_CYCLES(8)) ddsp_top_i (.core_clk_i(core_clk),
    .arst_n_i(arst_n), .link_sclk_i(sclk), .select_low_i(sel_low), .serial_in_pin_i(mosi),
    .serial_out_o(dout), .serial_out_oe_n_o(oe_n), .modulation_input_a_i(mod_a),
    .modulation_input_b_i(mod_b), .over_current_i(ovc), .open_load_i(17'h00000),
    .over_temp_i(otemp), .temp_warning_i(1'b0), .supply_fail_i(1'b0), .stage_drive_o(drive),
    .summary_error_flag_o(ef), .thermal_shutdown_flag_o(thermal_shutdown_flag));
  ////////////////////////////////////////////////////////////////////////////
  // Note the expected reply, then let the host send the frame.
  task automatic frame(input logic [15:0] tx, input logic [16:0] e);
    exp_q.push_back(e);
    ddsp_host_model_i.xfer(tx);
  endtask : frame
  // Print the counts and the verdict, then stop.
  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // Each finished frame is compared with the oldest note.
  always @(ddsp_host_model_i.done) begin
    exp_frame = exp_q.pop_front();
    `DDSP_CHK("frame", exp_frame, ddsp_host_model_i.last_rx)
  end
  // A hang counts as a mismatch.
  initial begin
    #400000 n_fail++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [16:0] z;
    logic want;
    z = 17'h00000;
    {arst_n, mod_a, mod_b, otemp, ovc} = {4'h0, z};
    void'($urandom(32'h0ede));
    repeat (2) @(posedge core_clk);
    @(negedge core_clk) arst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    frame(16'h8000, z); // First read returns register zero.
    `DDSP_CHK("drive", 17'h00001, drive)
    // One frame swaps the two sides of bridge zero, then swaps them back.
    frame(16'h4000, z);
    `DDSP_CHK("swap", 17'h00002, drive)
    frame(16'h8000, z);
    `DDSP_CHK("swap back", 17'h00001, drive)
    // Every selection pair against random modulation levels.
    for (int s = 0; s < 4; s++) begin
      frame({s[0], 15'h0001}, z);
      frame({s[1], 15'h0003}, z);
      for (int k = 0; k < 4; k++) begin
        @(negedge core_clk) {mod_a, mod_b} = 2'($urandom); // Faster than advised.
        repeat (16) @(negedge core_clk);
        want = (s == 0) ? 1'b1 : (s == 1) ? mod_a : (s == 2) ? mod_b : (mod_a | mod_b);
        `DDSP_CHK("modulated", want, drive[0])
      end
    end
    frame(16'h0000, z);
    `DDSP_CHK("on bit low", 1'b0, drive[0])
    // Both switches of a bridge requested, then reads and a delayed clear.
    frame(16'hc000, z);
    `DDSP_CHK("conflict", z, drive)
    `DDSP_CHK("summary flag", 1'b1, ef)
    frame(16'h0002, 17'h1c000);
    frame(16'h0004, 17'h10001);
    frame(16'h0000, 17'h1c000);
    frame(16'h0000, z);
    // Overcurrent past the delay, then an over temperature.
    // Switch zero and the lone switch six on; only switch zero sees an overcurrent.
    @(negedge core_clk) {mod_a, mod_b} = 2'h3;
    frame(16'h8200, z);
    @(negedge core_clk) ovc[0] = 1'b1;
    repeat (SD + 20) @(negedge core_clk);
    ovc[0] = 1'b0;
    repeat (10) @(negedge core_clk);
    `DDSP_CHK("overcurrent", 1'b0, drive[0])
    otemp = 1'b1;
    repeat (10) @(negedge core_clk);
    otemp = 1'b0;
    repeat (4) @(negedge core_clk);
    `DDSP_CHK("thermal", 1'b1, thermal_shutdown_flag)
    `DDSP_CHK("thermal off", z, drive)
    frame(16'h0001, 17'h18210);
    frame(16'h0005, 17'h10011);
    frame(16'h0000, 17'h10011);
    frame(16'h0000, 17'h18200);
    `DDSP_CHK("thermal cleared", 1'b0, thermal_shutdown_flag)
    report_and_stop();
  end
endmodule : ddsp_tb_top
`default_nettype wire
